/* msp_status_regs.sv */
// Purpose: read-only link status and 64-bit event counters for a memory controller
// Assumes: status and events come from logic on ref_clk_i, so no synchronisers
// Notes:   counters read as two words, low word at even index, high word next
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps

module msp_status_regs
  import msp_pkg::*;
#(
  parameter int unsigned NUM_LANES = 16
)
(
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      rstn_i,
  // link logic
  input  wire msp_pkg::msp_status_t      status_i,
  input  wire msp_pkg::msp_events_t      events_i,
  // register port
  input  wire msp_pkg::msp_req_t         req_i,
  output logic [msp_pkg::DATA_W-1:0]     rdata_o
);
  import msp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    msp_status_t                 stat;
    logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
    logic [DATA_W-1:0]           rdata;
  } msp_state_t;

  msp_state_t state;
  msp_state_t next_state;

  localparam logic [MAX_LANES-1:0] LANE_MASK = MAX_LANES'((17'h1 << NUM_LANES) - 17'h1);

  function automatic logic [DATA_W-1:0] lane_word(input logic [MAX_LANES-1:0] m);
    lane_word = {16'h0000, m & LANE_MASK};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [NUM_CNT-1:0] ev;
    logic [ADDR_W-1:0]  idx;
    next_state = state;
    ev         = events_i;
    idx        = req_i.addr - OFS_CNT_BASE;
    // status fields follow the link logic every cycle
    next_state.stat = status_i;
    next_state.stat.lane_lock_map          = status_i.lane_lock_map & LANE_MASK;
    next_state.stat.lane_partial_align_map = status_i.lane_partial_align_map & LANE_MASK;
    next_state.stat.lane_full_align_map    = status_i.lane_full_align_map & LANE_MASK;
    next_state.stat.lane_inversion_map     = status_i.lane_inversion_map & LANE_MASK;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      if (ev[i])
      begin
        next_state.cnt[i] = state.cnt[i] + 64'h1;
      end
    end
    // read data is held between reads; writes never touch state
    if (req_i.rd)
    begin
      case (req_i.addr)
        OFS_GENERAL:
        begin
          next_state.rdata = RST_ZERO;
          next_state.rdata[GEN_LINK_UP_BIT] = state.stat.link_operational_flag;
          next_state.rdata[GEN_TRAIN_BIT]   = state.stat.training_active_flag;
          next_state.rdata[GEN_SLEEP_BIT]   = state.stat.low_power_active_flag;
          next_state.rdata[GEN_MIRROR_BIT]  = state.stat.lane_order_mirrored_flag;
          next_state.rdata[GEN_SERDES_BIT]  = state.stat.serdes_ready_flag;
        end
        OFS_CREDIT:
        begin
          next_state.rdata = RST_ZERO;
          next_state.rdata[CRD_REMOTE_LSB +: CREDIT_W] = state.stat.remote_buffer_credit;
          next_state.rdata[CRD_LOCAL_LSB +: CREDIT_W]  = state.stat.local_buffer_credit;
        end
        OFS_INVERT: next_state.rdata = lane_word(state.stat.lane_inversion_map);
        OFS_LOCK:   next_state.rdata = lane_word(state.stat.lane_lock_map);
        OFS_ALIGN:
        begin
          next_state.rdata = lane_word(state.stat.lane_partial_align_map);
          next_state.rdata[ALN_FULL_LSB +: MAX_LANES] = state.stat.lane_full_align_map;
        end
        OFS_INIT:
        begin
          next_state.rdata = RST_ZERO;
          next_state.rdata[INIT_PHASE_LSB +: 2] = state.stat.transmit_init_phase;
          // summary derived here so it always agrees with the full map
          next_state.rdata[INIT_ALL_BIT] =
            (state.stat.lane_full_align_map == LANE_MASK);
          next_state.rdata[INIT_REMOTE_BIT] = state.stat.remote_training_seen_flag;
        end
        default:
        begin
          // counters: two words each; anything else reads zero
          if (req_i.addr >= OFS_CNT_BASE && idx < ADDR_W'(2 * NUM_CNT))
          begin
            next_state.rdata = idx[0] ? state.cnt[idx[3:1]][63:32]
                                      : state.cnt[idx[3:1]][31:0];
          end
          else
          begin
            next_state.rdata = RST_ZERO;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rdata_o = state.rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_bad_count_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    events_i.bad_packet |=> state.cnt[CNT_BAD] == $past(state.cnt[CNT_BAD]) + 64'h1)
    else $error("bad packet counter did not step");
  a_nonposted_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    events_i.nonposted_request |=> state.cnt[CNT_NONPOST] == $past(state.cnt[CNT_NONPOST]) + 64'h1)
    else $error("nonposted counter did not step");
  a_posted_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    events_i.posted_write |=> state.cnt[CNT_POSTED] == $past(state.cnt[CNT_POSTED]) + 64'h1)
    else $error("posted counter did not step");
  a_read_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !events_i.read_request |=> $stable(state.cnt[CNT_READ]))
    else $error("read counter moved without event");
  a_resp_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    events_i.response |=> state.cnt[CNT_RESP] == $past(state.cnt[CNT_RESP]) + 64'h1)
    else $error("response counter did not step");
  a_write_ignored: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    req_i.wr && !req_i.rd |=> $stable(state.rdata))
    else $error("write altered read data");
  a_general_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    req_i.rd && req_i.addr == OFS_GENERAL |=>
      rdata_o[GEN_LINK_UP_BIT] == $past(state.stat.link_operational_flag))
    else $error("link ready readback wrong");
  a_all_aligned: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    req_i.rd && req_i.addr == OFS_INIT |=>
      rdata_o[INIT_ALL_BIT] == ($past(state.stat.lane_full_align_map) == LANE_MASK))
    else $error("summary alignment bit wrong");

  // ----------------------------------------------------------------
  // readback checks
  // ----------------------------------------------------------------
  // a read is taken at one edge and its word must stand at the next one
  sequence s_read_at(logic [ADDR_W-1:0] a);
    req_i.rd && req_i.addr == a;
  endsequence

  a_train_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_GENERAL) |=>
      rdata_o[GEN_TRAIN_BIT] == $past(state.stat.training_active_flag))
    else $error("training flag readback wrong");

  a_sleep_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_GENERAL) |=>
      rdata_o[GEN_SLEEP_BIT] == $past(state.stat.low_power_active_flag))
    else $error("low power flag readback wrong");

  a_mirror_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_GENERAL) |=>
      rdata_o[GEN_MIRROR_BIT] == $past(state.stat.lane_order_mirrored_flag))
    else $error("lane order flag readback wrong");

  a_serdes_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_GENERAL) |=>
      rdata_o[GEN_SERDES_BIT] == $past(state.stat.serdes_ready_flag))
    else $error("serdes ready flag readback wrong");

  a_general_spare: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_GENERAL) |=>
      rdata_o[DATA_W-1:GEN_SERDES_BIT+1] == '0)
    else $error("general word spare bits not zero");

  a_remote_credit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_CREDIT) |=>
      rdata_o[CRD_REMOTE_LSB +: CREDIT_W] == $past(state.stat.remote_buffer_credit))
    else $error("remote credit readback wrong");

  a_local_credit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_CREDIT) |=>
      rdata_o[CRD_LOCAL_LSB +: CREDIT_W] == $past(state.stat.local_buffer_credit))
    else $error("local credit readback wrong");

  a_credit_spare: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_CREDIT) |=>
      rdata_o[CRD_LOCAL_LSB-1:CREDIT_W] == '0 && rdata_o[DATA_W-1:CRD_LOCAL_LSB+CREDIT_W] == '0)
    else $error("credit word spare bits not zero");

  a_invert_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_INVERT) |=>
      rdata_o == lane_word($past(state.stat.lane_inversion_map)))
    else $error("inversion map readback wrong");

  a_lock_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_LOCK) |=>
      rdata_o == lane_word($past(state.stat.lane_lock_map)))
    else $error("lock map readback wrong");

  a_partial_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_ALIGN) |=>
      rdata_o[MAX_LANES-1:0] == ($past(state.stat.lane_partial_align_map) & LANE_MASK))
    else $error("partial align map readback wrong");

  a_full_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_ALIGN) |=>
      rdata_o[ALN_FULL_LSB +: MAX_LANES] == $past(state.stat.lane_full_align_map))
    else $error("full align map readback wrong");

  a_summary_clear: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_INIT) ##0 state.stat.lane_full_align_map != LANE_MASK |=>
      !rdata_o[INIT_ALL_BIT])
    else $error("summary bit set with a lane unaligned");

  a_phase_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_INIT) |=>
      rdata_o[INIT_PHASE_LSB +: 2] == $past(state.stat.transmit_init_phase))
    else $error("init phase readback wrong");

  a_remote_ts_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_INIT) |=>
      rdata_o[INIT_REMOTE_BIT] == $past(state.stat.remote_training_seen_flag))
    else $error("remote training flag readback wrong");

  a_init_spare: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(OFS_INIT) |=>
      rdata_o[DATA_W-1:INIT_REMOTE_BIT+1] == '0)
    else $error("init word spare bits not zero");

  a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_INIT + 8'h01)) |=> rdata_o == '0)
    else $error("unmapped word not zero");

  a_rdata_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !req_i.rd |=> $stable(rdata_o))
    else $error("read data moved without a read");

  // ----------------------------------------------------------------
  // mirror and reset checks
  // ----------------------------------------------------------------
  a_status_mirror: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    1'b1 |=> state.stat.link_operational_flag == $past(status_i.link_operational_flag))
    else $error("link ready flag not mirrored");

  a_credit_mirror: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    1'b1 |=> state.stat.remote_buffer_credit == $past(status_i.remote_buffer_credit))
    else $error("remote credit not mirrored");

  // no disable here: this one guards the reset itself
  a_reset_zero: assert property (@(posedge ref_clk_i)
    !rstn_i |=> rdata_o == '0 && state.cnt == '0 && state.stat == '0)
    else $error("state not cleared by reset");

  // ----------------------------------------------------------------
  // counter checks
  // ----------------------------------------------------------------
  a_read_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    events_i.read_request |=> state.cnt[CNT_READ] == $past(state.cnt[CNT_READ]) + 64'h1)
    else $error("read counter did not step");

  a_bad_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !events_i.bad_packet |=> $stable(state.cnt[CNT_BAD]))
    else $error("bad packet counter moved without event");

  a_nonposted_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !events_i.nonposted_request |=> $stable(state.cnt[CNT_NONPOST]))
    else $error("nonposted counter moved without event");

  a_posted_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !events_i.posted_write |=> $stable(state.cnt[CNT_POSTED]))
    else $error("posted counter moved without event");

  a_resp_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !events_i.response |=> $stable(state.cnt[CNT_RESP]))
    else $error("response counter moved without event");

  // low and high words are separate reads, so each is checked on its own
  a_bad_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_BAD)) |=>
      rdata_o == $past(state.cnt[CNT_BAD][31:0]))
    else $error("bad packet low word wrong");

  a_bad_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_BAD + 1)) |=>
      rdata_o == $past(state.cnt[CNT_BAD][63:32]))
    else $error("bad packet high word wrong");

  a_nonposted_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_NONPOST)) |=>
      rdata_o == $past(state.cnt[CNT_NONPOST][31:0]))
    else $error("nonposted low word wrong");

  a_nonposted_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_NONPOST + 1)) |=>
      rdata_o == $past(state.cnt[CNT_NONPOST][63:32]))
    else $error("nonposted high word wrong");

  a_posted_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_POSTED)) |=>
      rdata_o == $past(state.cnt[CNT_POSTED][31:0]))
    else $error("posted low word wrong");

  a_posted_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_POSTED + 1)) |=>
      rdata_o == $past(state.cnt[CNT_POSTED][63:32]))
    else $error("posted high word wrong");

  a_read_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_READ)) |=>
      rdata_o == $past(state.cnt[CNT_READ][31:0]))
    else $error("read counter low word wrong");

  a_read_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_READ + 1)) |=>
      rdata_o == $past(state.cnt[CNT_READ][63:32]))
    else $error("read counter high word wrong");

  a_resp_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_RESP)) |=>
      rdata_o == $past(state.cnt[CNT_RESP][31:0]))
    else $error("response low word wrong");

  a_resp_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_read_at(ADDR_W'(OFS_CNT_BASE + 2 * CNT_RESP + 1)) |=>
      rdata_o == $past(state.cnt[CNT_RESP][63:32]))
    else $error("response high word wrong");

endmodule // msp_status_regs

/* msp_pkg.sv */
// Purpose: shared constants and types for the status and performance register bank
// Assumes: plain register port, 32-bit read data, word addresses
// Notes:   offsets are word indices on the register port
package msp_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned CREDIT_W    = 10;
  localparam int unsigned CNT_W       = 64;
  localparam int unsigned MAX_LANES   = 16;
  localparam int unsigned NUM_CNT     = 5;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_GENERAL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CREDIT   = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_INVERT   = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_LOCK     = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_ALIGN    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INIT     = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_CNT_BASE = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned GEN_LINK_UP_BIT  = 0;
  localparam int unsigned GEN_TRAIN_BIT    = 1;
  localparam int unsigned GEN_SLEEP_BIT    = 2;
  localparam int unsigned GEN_MIRROR_BIT   = 3;
  localparam int unsigned GEN_SERDES_BIT   = 4;
  localparam int unsigned CRD_REMOTE_LSB   = 0;
  localparam int unsigned CRD_LOCAL_LSB    = 16;
  localparam int unsigned ALN_FULL_LSB     = 16;
  localparam int unsigned INIT_PHASE_LSB   = 0;
  localparam int unsigned INIT_ALL_BIT     = 2;
  localparam int unsigned INIT_REMOTE_BIT  = 3;

  // ----------------------------------------------------------------
  // counter indices
  // ----------------------------------------------------------------
  localparam int unsigned CNT_BAD      = 0;
  localparam int unsigned CNT_NONPOST  = 1;
  localparam int unsigned CNT_POSTED   = 2;
  localparam int unsigned CNT_READ     = 3;
  localparam int unsigned CNT_RESP     = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;

  // transmit init phase encodings
  typedef enum logic [1:0] {
    first_null_phase        = 2'h0,
    training_sequence_phase = 2'h1,
    second_null_phase       = 2'h3
  } msp_tx_phase_t;

  // link status from the controller's link logic
  typedef struct packed {
    logic                 link_operational_flag;
    logic                 training_active_flag;
    logic                 low_power_active_flag;
    logic                 lane_order_mirrored_flag;
    logic                 serdes_ready_flag;
    logic [CREDIT_W-1:0]  remote_buffer_credit;
    logic [CREDIT_W-1:0]  local_buffer_credit;
    logic [MAX_LANES-1:0] lane_inversion_map;
    logic [MAX_LANES-1:0] lane_lock_map;
    logic [MAX_LANES-1:0] lane_partial_align_map;
    logic [MAX_LANES-1:0] lane_full_align_map;
    logic [1:0]           transmit_init_phase;
    logic                 remote_training_seen_flag;
  } msp_status_t;

  // one-cycle event pulses, one per counter
  typedef struct packed {
    logic response;
    logic read_request;
    logic posted_write;
    logic nonposted_request;
    logic bad_packet;
  } msp_events_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } msp_req_t;

endpackage

/* msp_status_regs_tb.sv */
// Purpose: self-checking bench for the status and event counter register bank
// Assumes: one clock; read data stand in the cycle after the read strobe
// Notes:   a 64-bit wrap is out of reach in a run, only the step of one is checked
`timescale 1ns/1ps
module msp_status_regs_tb;
  import msp_pkg::*;
  logic              ref_clk_i;
  logic              rstn_i;
  msp_status_t       status_i;
  msp_events_t       events_i;
  msp_req_t          req_i;
  logic [DATA_W-1:0] rdata_o;
  logic [CNT_W-1:0]  cnt_m [NUM_CNT];
  int                n_fail;
  int                compares;

  msp_status_regs #(.NUM_LANES(16)) msp_status_regs_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .status_i(status_i),
    .events_i(events_i), .req_i(req_i), .rdata_o(rdata_o));

  always #10 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] exp_word(input logic [ADDR_W-1:0] a);
    msp_status_t      s;
    logic [CNT_W-1:0] c;
    s = status_i;
    c = '0;
    case (a)
      OFS_GENERAL: exp_word = {27'h0, s.serdes_ready_flag, s.lane_order_mirrored_flag,
                               s.low_power_active_flag, s.training_active_flag,
                               s.link_operational_flag};
      OFS_CREDIT:  exp_word = {6'h0, s.local_buffer_credit, 6'h0, s.remote_buffer_credit};
      OFS_INVERT:  exp_word = {16'h0, s.lane_inversion_map};
      OFS_LOCK:    exp_word = {16'h0, s.lane_lock_map};
      OFS_ALIGN:   exp_word = {s.lane_full_align_map, s.lane_partial_align_map};
      OFS_INIT:    exp_word = {28'h0, s.remote_training_seen_flag,
                               s.lane_full_align_map == 16'hffff, s.transmit_init_phase};
      default:
      begin
        if (a >= OFS_CNT_BASE && a < OFS_CNT_BASE + 8'(2 * NUM_CNT))
          c = cnt_m[(a - OFS_CNT_BASE) >> 1];
        // unmapped places read zero, c stays zero for them
        exp_word = a[0] ? c[63:32] : c[31:0];
      end
    endcase
  endfunction

  function automatic msp_status_t rand_status(input int i);
    logic [95:0] r;
    msp_status_t s;
    r = {$urandom, $urandom, $urandom};
    s = r[$bits(msp_status_t)-1:0];
    // only the three documented phase codes are driven
    case (i % 3)
      0: s.transmit_init_phase = first_null_phase;
      1: s.transmit_init_phase = training_sequence_phase;
      default: s.transmit_init_phase = second_null_phase;
    endcase
    if (i % 4 == 1) s.lane_full_align_map = 16'hffff;
    if (i % 4 == 3) s.lane_full_align_map = 16'hfffe;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got,
                     input logic [ADDR_W-1:0] a);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t word %h got %h exp %h", $time, a, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk_i);
    req_i.addr <= a;
    req_i.rd   <= 1'b1;
    @(posedge ref_clk_i);
    req_i.rd   <= 1'b0;
    #1;
    chk(exp_word(a), rdata_o, a);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    req_i.addr  <= a;
    req_i.wdata <= d;
    req_i.wr    <= 1'b1;
    @(posedge ref_clk_i);
    req_i.wr    <= 1'b0;
  endtask

  task automatic sweep(input string name);
    for (int a = 0; a < 32; a++) rd_chk(8'(a));
    rd_chk(8'hff);
    $display("test %s done", name);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    rstn_i = 1'b0;
    status_i = '0;
    events_i = '0;
    req_i = '0;
    n_fail = 0;
    compares = 0;
    foreach (cnt_m[k]) cnt_m[k] = '0;
    void'($urandom(32'h9719));
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    sweep("reset");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk_i);
      status_i <= rand_status(i);
      sweep("status");
    end
    for (int a = 0; a < 32; a++) wr(8'(a), $urandom);
    sweep("writes");
    for (int i = 0; i < 300; i++)
    begin
      msp_events_t ev;
      ev = (i >= 100 && i < 108) ? 5'h1f : 5'($urandom);
      @(posedge ref_clk_i);
      events_i <= ev;
      for (int k = 0; k < NUM_CNT; k++) cnt_m[k] += 64'(ev[k]);
    end
    @(posedge ref_clk_i);
    events_i <= '0;
    sweep("events");
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    foreach (cnt_m[k]) cnt_m[k] = '0;
    sweep("second reset");
    results();
  end

  // a full run needs about 1200 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog ran out", $time);
    results();
  end
endmodule // msp_status_regs_tb
